// ==== dv/ilf_core_bench.sv ====
// testbench: lock, fuse and polling scenarios for the core
`timescale 1ns/1ns
module ilf_core_bench;
  import ilf_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, wr_is_code = 1'b0, prog_busy = 1'b0, erase_busy = 1'b0;
  logic write_inhibit_flag = 1'b1, rd_is_code = 1'b0, wr_valid, rd_blocked, busy_n;
  logic [3:0] ev = 4'h0;
  logic [15:0] rd_addr = 16'h0000;
  logic [7:0] rd_mem_data = 8'h00, rd_data;
  logic [1:0] lock_bits;
  logic [18:0] fuse_bits;
  ilf_lock_e lock_mode;
  ilf_cfg_s cfg;
  ilf_req_s wr_req;
  int n_errors = 0, samples_checked = 0;
  always #20 clock = ~clock;
  ilf_prog_model pm (.clock(clock), .wr_valid(wr_valid), .wr_req(wr_req));
  ilf_core uut (.clock(clock), .nrst(nrst), .por_pulse(ev[0]), .session_end(ev[1]),
    .wr_valid(wr_valid), .wr_req(wr_req), .wr_is_code(wr_is_code), .wr_is_user_sig(1'b0),
    .prog_busy(prog_busy), .erase_busy(erase_busy), .chip_erase(ev[2]),
    .fuse_row_erase(ev[3]), .write_inhibit_flag(write_inhibit_flag), .rd_is_code(rd_is_code),
    .rd_addr(rd_addr), .rd_mem_data(rd_mem_data), .rd_data(rd_data), .rd_blocked(rd_blocked),
    .lock_bits(lock_bits), .lock_mode(lock_mode), .fuse_bits(fuse_bits), .wr_refused(),
    .status_busy_n(busy_n), .cfg(cfg), .comparator_input_a_input_only(),
    .comparator_input_b_input_only(), .slave_select_quasi_bidir());
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: exp %0h got %0h", $time, exp, got);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    ev[k] <= 1'b1;
    @(posedge clock);
    ev[k] <= 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic p, input logic e, input logic w, input logic [7:0] m);
    @(posedge clock);
    prog_busy <= p;
    erase_busy <= e;
    write_inhibit_flag <= w;
    rd_mem_data <= m;
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic t_poll;
    @(posedge clock);
    wr_is_code <= 1'b1;
    rd_addr <= 16'h0123;
    pm.send(8'h50, 16'h0124, 8'h5A);
    pm.send(8'h50, 16'h0123, 8'h3C);
    wr_is_code <= 1'b0;
    rd(1'b1, 1'b0, 1'b1, 8'hC3);
    check(8'hBC, rd_data);
    check(1'b0, busy_n);
    rd(1'b0, 1'b0, 1'b1, 8'h3C);
    check(8'h3C, rd_data);
    rd(1'b0, 1'b1, 1'b1, 8'h3C);
    check(8'h7F, rd_data);
    rd(1'b0, 1'b0, 1'b0, 8'h3C);
    check(1'b0, busy_n);
    rd(1'b0, 1'b0, 1'b1, 8'h3C);
    $display("test poll done");
  endtask
  task automatic t_fuse;
    int prev = 3;
    for (int i = 0; i < 4; i++) begin
      pulse(3);
      pm.set_fuse(ILF_FA_CLK0, i[0]);
      pm.set_fuse(ILF_FA_CLK1, i[1]);
      @(negedge clock);
      check(prev, cfg.clock_source);
      pulse(0);
      check(i, cfg.clock_source);
      if (i != 1) check(i == 0 ? ILF_SUT_X3_US : ILF_SUT_O3_US, cfg.wakeup_timeout_us);
      prev = i;
    end
    for (int k = 4; k < ILF_NUM_FUSES; k++) begin
      if (k != 6 && k != 16 && k != 17) pm.set_fuse(5'(k), 1'b1);
    end
    pm.set_fuse(ILF_FA_RSTPIN, 1'b0);
    pm.set_fuse(ILF_FA_SDD, 1'b0);
    pm.set_fuse(ILF_FA_ISP, 1'b0);
    pm.set_fuse(ILF_FA_DBGIF, 1'b0);
    pm.set_fuse(5'h13, 1'b0);
    @(negedge clock);
    check(ILF_FUSE_RESET & ~19'h400B0, fuse_bits);
    check(2'h3, {cfg.debug_if_bad, cfg.reset_pin_is_reset});
    pulse(1);
    check(2'h0, {cfg.isp_enabled, cfg.reset_pin_is_reset});
    pulse(3);
    check(ILF_FUSE_RESET, fuse_bits);
    $display("test fuse done");
  endtask
  task automatic t_lock;
    pm.send(ILF_OP_LOCK_WR, 16'h0000, ILF_BYTE_ZERO);
    pm.set_fuse(ILF_FA_SDD, 1'b0);
    @(negedge clock);
    check(ILF_LOCK_MODE2, lock_mode);
    check(ILF_FUSE_RESET, fuse_bits);
    pm.send(ILF_OP_LOCK_WR, 16'h0001, ILF_BYTE_ZERO);
    rd_is_code <= 1'b1;
    rd(1'b0, 1'b0, 1'b1, 8'h55);
    check(ILF_LOCK_MODE3, lock_mode);
    check(9'h100, {rd_blocked, rd_data});
    rd_is_code <= 1'b0;
    rd(1'b0, 1'b0, 1'b1, 8'h55);
    check(9'h055, {rd_blocked, rd_data});
    pulse(2);
    check(ILF_LOCK_RESET, lock_bits);
    $display("test lock done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    check(ILF_FUSE_RESET, fuse_bits);
    check(ILF_LOCK_RESET, lock_bits);
    t_poll;
    t_fuse;
    t_lock;
    results;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    results;
  end
endmodule // ilf_core_bench

// ==== dv/ilf_core_monitor.sv ====
// checker: lock, fuse and polling properties at the core ports
`timescale 1ns/1ns
module ilf_core_monitor (
  // clock, reset and inputs
  input wire logic clock,
  input wire logic nrst,
  input wire logic wr_valid,
  input wire ilf_pkg::ilf_req_s wr_req,
  input wire logic prog_busy,
  input wire logic erase_busy,
  input wire logic chip_erase,
  input wire logic fuse_row_erase,
  input wire logic write_inhibit_flag,
  input wire logic rd_is_code,
  // outputs
  input wire logic [7:0] rd_data,
  input wire logic rd_blocked,
  input wire logic [1:0] lock_bits,
  input wire ilf_pkg::ilf_lock_e lock_mode,
  input wire logic [18:0] fuse_bits,
  input wire logic wr_refused,
  input wire logic status_busy_n,
  input wire ilf_pkg::ilf_cfg_s cfg,
  input wire logic comparator_input_a_input_only,
  input wire logic comparator_input_b_input_only,
  input wire logic slave_select_quasi_bidir
);
  import ilf_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_lock_mode_map: assert property (
    lock_bits != 2'h1 |-> lock_mode == (lock_bits == 2'h3 ? ILF_LOCK_MODE1 :
    lock_bits == 2'h2 ? ILF_LOCK_MODE2 : ILF_LOCK_MODE3)) else $error("lock mode wrong");
  a_lock_no_set: assert property (
    !chip_erase |=> (lock_bits & ~$past(lock_bits)) == 2'h0) else $error("lock bit set");
  a_refuse_locked: assert property (
    wr_valid && wr_req.opcode != ILF_OP_LOCK_WR && lock_mode != ILF_LOCK_MODE1 |-> wr_refused)
    else $error("write not refused");
  a_fuse_locked: assert property (
    lock_mode != ILF_LOCK_MODE1 && !fuse_row_erase |=> $stable(fuse_bits))
    else $error("fuse changed while locked");
  a_fuse_ff_keep: assert property (
    wr_valid && wr_req.data == ILF_BYTE_ONES && !fuse_row_erase |=> $stable(fuse_bits))
    else $error("ones write changed fuses");
  a_code_block: assert property (
    lock_mode == ILF_LOCK_MODE3 && rd_is_code && !chip_erase |=> rd_blocked &&
    rd_data == ILF_BYTE_ZERO) else $error("code read not blocked");
  a_busy_flag: assert property (
    status_busy_n == !(prog_busy || erase_busy || !write_inhibit_flag)) else $error("busy");
  a_cfg_direct: assert property (
    cfg.supply_drop_detector_en == fuse_bits[5] && cfg.user_sig_prog_en == !fuse_bits[16] &&
    cfg.ports_start_tristate == fuse_bits[17] && cfg.rc_trim == fuse_bits[15:8])
    else $error("cfg mismatch");
  a_debug_en: assert property (
    cfg.onchip_debug_en == (!fuse_bits[6] && lock_mode != ILF_LOCK_MODE3)) else $error("debug");
  a_pin_reset: assert property (
    comparator_input_a_input_only && comparator_input_b_input_only && slave_select_quasi_bidir)
    else $error("pin reset modes");
  c_mode3: cover property (lock_mode == ILF_LOCK_MODE3);
  c_refused: cover property (wr_refused);
  c_erase_poll: cover property (erase_busy && rd_data == 8'h7F);
endmodule // ilf_core_monitor
bind ilf_core ilf_core_monitor mon (.clock, .nrst, .wr_valid, .wr_req, .prog_busy, .erase_busy,
  .chip_erase, .fuse_row_erase, .write_inhibit_flag, .rd_is_code, .rd_data, .rd_blocked,
  .lock_bits, .lock_mode, .fuse_bits, .wr_refused, .status_busy_n, .cfg,
  .comparator_input_a_input_only, .comparator_input_b_input_only, .slave_select_quasi_bidir);

// ==== dv/ilf_prog_model.sv ====
// programmer model: single-byte write requests toward the device
`timescale 1ns/1ns
module ilf_prog_model (
  // clock
  input wire logic clock,
  // write request
  output logic wr_valid,
  output ilf_pkg::ilf_req_s wr_req
);
  import ilf_pkg::*;
  initial begin
    wr_valid = 1'b0;
    wr_req = '0;
  end
  task automatic send(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_valid <= 1'b1;
    wr_req <= '{opcode: op, addr: a, data: d};
    @(posedge clock);
    wr_valid <= 1'b0;
    wr_req <= '{opcode: ~op, addr: ~a, data: ~d};
  endtask
  // only 00h or ffh, zero high address, auto-erase opcode
  task automatic set_fuse(input logic [4:0] fa, input logic on);
    send(ILF_OP_FUSE_WR_AE, {11'h000, fa}, on ? ILF_BYTE_ONES : ILF_BYTE_ZERO);
  endtask
endmodule // ilf_prog_model

// ==== hdl/ilf_core.sv ====
// module: lock bits, user fuse row and busy-indication polling
`timescale 1ns/1ns
module ilf_core (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // power-on and session events
  input wire logic por_pulse,
  input wire logic session_end,
  // write requests
  input wire logic wr_valid,
  input wire ilf_pkg::ilf_req_s wr_req,
  input wire logic wr_is_code,
  input wire logic wr_is_user_sig,
  // programming cycle state
  input wire logic prog_busy,
  input wire logic erase_busy,
  input wire logic chip_erase,
  input wire logic fuse_row_erase,
  input wire logic write_inhibit_flag,
  // read path
  input wire logic rd_is_code,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0] rd_mem_data,
  output logic [7:0] rd_data,
  output logic rd_blocked,
  // lock and fuse view
  output logic [1:0] lock_bits,
  output ilf_pkg::ilf_lock_e lock_mode,
  output logic [18:0] fuse_bits,
  output logic wr_refused,
  output logic status_busy_n,
  // configuration outputs
  output ilf_pkg::ilf_cfg_s cfg,
  output logic comparator_input_a_input_only,
  output logic comparator_input_b_input_only,
  output logic slave_select_quasi_bidir
);
  import ilf_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [1:0] lock_q;
  logic [1:0] lock_d;
  logic [18:0] fuse_q;
  logic [18:0] fuse_d;
  logic [15:0] last_addr_q;
  logic [7:0] last_data_q;
  logic last_valid_q;
  logic [1:0] clk_sel_q;
  logic rstpin_q;
  logic isp_q;
  logic [7:0] rd_data_q;
  logic rd_blocked_q;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  wire is_fuse_wr = (wr_req.opcode == ILF_OP_FUSE_WR) || (wr_req.opcode == ILF_OP_FUSE_WR_AE);
  wire is_lock_wr = wr_req.opcode == ILF_OP_LOCK_WR;
  wire hi_zero = wr_req.addr[15:8] == ILF_BYTE_ZERO;
  wire [4:0] byte_addr = wr_req.addr[4:0];
  wire data_zero = wr_req.data == ILF_BYTE_ZERO;
  wire mode_ge2 = ~lock_q[0];
  wire mode3 = ~lock_q[0] & ~lock_q[1];
  wire usig_blocked = fuse_q[ILF_FA_USIG];
  // lock writes stay open in mode 2 so the row can still advance to mode 3
  wire refuse = (mode_ge2 & ~is_lock_wr) | (wr_is_user_sig & usig_blocked);
  wire wr_ok = wr_valid & ~refuse & write_inhibit_flag;
  wire fuse_hit = wr_ok & is_fuse_wr & hi_zero & (byte_addr < 5'(ILF_NUM_FUSES));
  wire lock_hit = wr_ok & is_lock_wr & hi_zero & (byte_addr < 5'(ILF_NUM_LOCKS));
  wire data_wr = wr_ok & (wr_is_code | wr_is_user_sig | is_fuse_wr | is_lock_wr);
  wire cycle_busy = prog_busy | erase_busy;
  wire poll_hit = cycle_busy & last_valid_q & (rd_addr == last_addr_q);
  wire [7:0] poll_ref = erase_busy ? ILF_BYTE_ONES : last_data_q;
  wire [7:0] poll_val = poll_ref ^ ILF_MSB_MASK;
  wire code_rd_block = rd_is_code & mode3;

  // only zero data clears; FFh leaves the bit alone
  always_comb begin
    fuse_d = fuse_q;
    if (fuse_row_erase) begin
      fuse_d = ILF_FUSE_RESET;
    end
    if (fuse_hit && data_zero) begin
      fuse_d[byte_addr] = 1'b0;
    end
  end

  // only chip erase sets lock bits back to ones
  always_comb begin
    lock_d = lock_q;
    if (chip_erase) begin
      lock_d = ILF_LOCK_RESET;
    end else if (lock_hit && data_zero) begin
      lock_d[byte_addr[0]] = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lock_q <= ILF_LOCK_RESET;
      fuse_q <= ILF_FUSE_RESET;
    end else begin
      lock_q <= lock_d;
      fuse_q <= fuse_d;
    end
  end

  // each byte accepted while no cycle is busy overwrites the reference, last one wins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_addr_q <= 16'h0000;
      last_data_q <= 8'h00;
      last_valid_q <= 1'b0;
    end else if (data_wr && !cycle_busy) begin
      last_addr_q <= wr_req.addr;
      last_data_q <= wr_req.data;
      last_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_sel_q <= 2'h3;
      rstpin_q <= 1'b1;
      isp_q <= 1'b1;
    end else begin
      if (por_pulse) begin
        clk_sel_q <= {fuse_q[ILF_FA_CLK1], fuse_q[ILF_FA_CLK0]};
      end
      if (por_pulse || session_end) begin
        rstpin_q <= fuse_q[ILF_FA_RSTPIN];
        isp_q <= fuse_q[ILF_FA_ISP];
      end
    end
  end

  // read data registered one cycle after the address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 8'h00;
      rd_blocked_q <= 1'b0;
    end else begin
      rd_data_q <= code_rd_block ? ILF_BYTE_ZERO : (poll_hit ? poll_val : rd_mem_data);
      rd_blocked_q <= code_rd_block;
    end
  end

  // --------------------------------------------------------------------------
  // configuration decode
  // --------------------------------------------------------------------------
  wire [1:0] sut = {fuse_q[ILF_FA_SUT1], fuse_q[ILF_FA_SUT0]};
  wire is_crystal_osc = clk_sel_q == 2'h0;
  logic [15:0] sut_us;
  ilf_clk_e clk_src;

  always_comb begin
    unique case (clk_sel_q)
      2'h0: clk_src = ILF_CLK_CRYSTAL;
      2'h1: clk_src = ILF_CLK_RESERVED;
      2'h2: clk_src = ILF_CLK_EXTERNAL;
      2'h3: clk_src = ILF_CLK_INTERNAL_RC;
    endcase
  end

  always_comb begin
    unique case (sut)
      2'h0: sut_us = is_crystal_osc ? ILF_SUT_X0_US : ILF_SUT_O0_US;
      2'h1: sut_us = is_crystal_osc ? ILF_SUT_X1_US : ILF_SUT_O1_US;
      2'h2: sut_us = is_crystal_osc ? ILF_SUT_X2_US : ILF_SUT_O2_US;
      2'h3: sut_us = is_crystal_osc ? ILF_SUT_X3_US : ILF_SUT_O3_US;
    endcase
  end

  // trim fuses occupy row bits 8 to 15
  wire [7:0] trim = fuse_q[ILF_FA_TRIM_LO +: 8];

  always_comb begin
    cfg.clock_source = clk_src;
    cfg.wakeup_timeout_us = sut_us;
    cfg.reset_pin_is_reset = rstpin_q;
    cfg.supply_drop_detector_en = fuse_q[ILF_FA_SDD];
    cfg.onchip_debug_en = ~fuse_q[ILF_FA_DBG] & ~mode3;
    cfg.isp_enabled = isp_q;
    cfg.rc_trim = trim;
    cfg.user_sig_prog_en = ~usig_blocked;
    cfg.ports_start_tristate = fuse_q[ILF_FA_TRIS];
    cfg.debug_if_fast = fuse_q[ILF_FA_DBGIF];
    cfg.debug_if_bad = ~fuse_q[ILF_FA_DBGIF];
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign lock_bits = lock_q;
  assign lock_mode = mode3 ? ILF_LOCK_MODE3 : (mode_ge2 ? ILF_LOCK_MODE2 : ILF_LOCK_MODE1);
  assign fuse_bits = fuse_q;
  assign wr_refused = wr_valid & refuse;
  assign status_busy_n = ~cycle_busy & write_inhibit_flag;
  assign rd_data = rd_data_q;
  assign rd_blocked = rd_blocked_q;
  assign comparator_input_a_input_only = 1'b1;
  assign comparator_input_b_input_only = 1'b1;
  assign slave_select_quasi_bidir = 1'b1;
endmodule // ilf_core

// ==== shared/ilf_pkg.sv ====
// package: constants and carrier types for the lock, fuse and polling logic
// ----------------------------------------------------------------------------
// Functional notes
// - while programming, reading the last written byte returns it with msb inverted
// - during erase the polled data is taken as all ones, reading 7Fh
// - polling reference is the last byte loaded before programming starts
// - two lock bits at addresses 0 and 1 select protection mode 1, 2 or 3
// - lock bits return to unprogrammed only through chip erase
// - lock mode 2 or 3 refuses programming of every memory space except the lock bits
// - lock mode 3 blocks code reads and debug, signatures and fuses stay readable
// - nineteen fuses, one per address, all reset to all ones
// - writing 00h clears a fuse, writing FFh keeps its previous state
// - fuses 0 and 1 choose crystal, reserved, external clock or internal rc
// - fuses 2 and 3 choose the wake-up time-out, scaled by clock source
// - fuse 04h ones makes reset pin a reset, zeros makes it general io
// - fuse 05h ones enables the supply-drop detector, zeros disables it
// - fuse 06h ones disables on-chip debug, zeros enables it
// - fuse 07h ones enables serial programming, zeros allows entry at power-on only
// - fuses 08h to 0Fh trim the rc oscillator, factory copy at 0008h
// - fuse 10h ones blocks user signature programming, zeros allows it
// - fuse 11h ones starts ports tristated, zeros starts them quasi-bidirectional
// - comparator inputs always reset input-only, slave-select always quasi-bidirectional
// - fuse 12h ones selects fast two-wire debug, zeros is not for use
// - clock fuses act after power-on, reset-pin and programming fuses at session end
// - fuse write with auto-erase opcode is F1h, high address 0, five-bit address
// - status reports busy while programming or while writes are inhibited
// ----------------------------------------------------------------------------
package ilf_pkg;
  localparam logic [7:0] ILF_BYTE_ONES = 8'hFF;
  localparam logic [7:0] ILF_BYTE_ZERO = 8'h00;
  localparam logic [7:0] ILF_MSB_MASK = 8'h80;
  localparam int ILF_NUM_FUSES = 19;
  localparam int ILF_NUM_LOCKS = 2;
  localparam logic [4:0] ILF_FA_CLK0 = 5'h00;
  localparam logic [4:0] ILF_FA_CLK1 = 5'h01;
  localparam logic [4:0] ILF_FA_SUT0 = 5'h02;
  localparam logic [4:0] ILF_FA_SUT1 = 5'h03;
  localparam logic [4:0] ILF_FA_RSTPIN = 5'h04;
  localparam logic [4:0] ILF_FA_SDD = 5'h05;
  localparam logic [4:0] ILF_FA_DBG = 5'h06;
  localparam logic [4:0] ILF_FA_ISP = 5'h07;
  localparam int ILF_FA_TRIM_LO = 8;
  localparam logic [4:0] ILF_FA_USIG = 5'h10;
  localparam logic [4:0] ILF_FA_TRIS = 5'h11;
  localparam logic [4:0] ILF_FA_DBGIF = 5'h12;
  localparam logic [7:0] ILF_OP_FUSE_WR = 8'hE1;
  localparam logic [7:0] ILF_OP_FUSE_WR_AE = 8'hF1;
  localparam logic [7:0] ILF_OP_LOCK_WR = 8'hE4;
  localparam logic [15:0] ILF_FACTORY_TRIM_ADDR = 16'h0008;
  localparam logic [18:0] ILF_FUSE_RESET = 19'h7FFFF;
  localparam logic [1:0] ILF_LOCK_RESET = 2'h3;
  // wake-up time-outs in microseconds
  localparam logic [15:0] ILF_SUT_X0_US = 16'd1000;
  localparam logic [15:0] ILF_SUT_X1_US = 16'd2000;
  localparam logic [15:0] ILF_SUT_X2_US = 16'd4000;
  localparam logic [15:0] ILF_SUT_X3_US = 16'd16000;
  localparam logic [15:0] ILF_SUT_O0_US = 16'd16;
  localparam logic [15:0] ILF_SUT_O1_US = 16'd512;
  localparam logic [15:0] ILF_SUT_O2_US = 16'd1000;
  localparam logic [15:0] ILF_SUT_O3_US = 16'd4000;

  typedef enum logic [1:0] {
    ILF_CLK_CRYSTAL,
    ILF_CLK_RESERVED,
    ILF_CLK_EXTERNAL,
    ILF_CLK_INTERNAL_RC
  } ilf_clk_e;

  typedef enum logic [1:0] {
    ILF_LOCK_MODE1,
    ILF_LOCK_MODE2,
    ILF_LOCK_MODE3
  } ilf_lock_e;

  // one write request from the command decoder
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] addr;
    logic [7:0] data;
  } ilf_req_s;

  // configuration derived from the fuses
  typedef struct packed {
    ilf_clk_e clock_source;
    logic [15:0] wakeup_timeout_us;
    logic reset_pin_is_reset;
    logic supply_drop_detector_en;
    logic onchip_debug_en;
    logic isp_enabled;
    logic [7:0] rc_trim;
    logic user_sig_prog_en;
    logic ports_start_tristate;
    logic debug_if_fast;
    logic debug_if_bad;
  } ilf_cfg_s;
endpackage
